// ===== common/iecu_pkg.sv
// constants, field layout and types of the input edge capture unit
// assumes a 32-bit APB slave with byte addresses on paddr
package iecu_pkg;

  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int ADDR_W = 8;
  localparam int BUF_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam logic [PTR_W:0] BUF_FULL_COUNT = 3'h4;
  localparam int IRQ_W = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BUF = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ISTAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h0C;

  // capture_control field positions
  localparam int BIT_ON = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_FIRST_EDGE = 9;
  localparam int BIT_WIDE = 8;
  localparam int BIT_TIMER_SEL = 7;
  localparam int BIT_RATE_HI = 6;
  localparam int BIT_RATE_LO = 5;
  localparam int BIT_OVERFLOW = 4;
  localparam int BIT_NOT_EMPTY = 3;
  localparam int BIT_MODE_HI = 2;
  localparam int BIT_MODE_LO = 0;

  // interrupt status and mask bits
  localparam int IST_CAPTURE = 0;
  localparam int IST_OVERFLOW = 1;

  // capture_mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EDGE = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_DIV4 = 3'h4;
  localparam logic [2:0] MODE_DIV16 = 3'h5;
  localparam logic [2:0] MODE_EVERY = 3'h6;
  localparam logic [2:0] MODE_INT_ONLY = 3'h7;

  localparam logic [3:0] PRESC4_LAST = 4'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hF;

  typedef struct packed {
    logic on;
    logic idleStop;
    logic firstEdgeSelect;
    logic wideCapture;
    logic timerSelect;
    logic [1:0] interruptRate;
    logic [2:0] captureMode;
  } iecu_ctrl_t;

  typedef enum logic {IECU_WAIT_FIRST, IECU_RUN} iecu_phase_t;

endpackage : iecu_pkg

// ===== common/iecu_buf_if.sv
// carrier between the capture unit and its capture buffer
// assumes both ends run on the same mclk
`timescale 1ns/1ps
interface iecu_buf_if;
  import iecu_pkg::*;
  logic push;
  logic [DATA_W-1:0] pushData;
  logic pop;
  logic flush;
  logic [DATA_W-1:0] popData;
  logic full;
  logic empty;
  modport owner(output push, output pushData, output pop, output flush,
                input popData, input full, input empty);
  modport buffer(input push, input pushData, input pop, input flush,
                 output popData, output full, output empty);
endinterface : iecu_buf_if

// ===== src/iecu_capture_buffer.sv
// capture buffer: small first-in first-out store of captured counts
// assumes the owner never pushes while full; such a push is dropped
`timescale 1ns/1ps
module iecu_capture_buffer
  import iecu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  iecu_buf_if.buffer bus
);

  typedef struct packed {
    logic [BUF_DEPTH-1:0][DATA_W-1:0] mem;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] count;
  } iecu_buf_state_t;

  iecu_buf_state_t r;
  iecu_buf_state_t next_r;
  logic doPush;
  logic doPop;

  always_comb begin
    next_r = r;
    doPush = bus.push && (r.count != BUF_FULL_COUNT);
    doPop = bus.pop && (r.count != '0);
    if (bus.flush) begin
      next_r.wrPtr = '0;
      next_r.rdPtr = '0;
      next_r.count = '0;
    end else begin
      if (doPush) begin
        next_r.mem[r.wrPtr] = bus.pushData;
        next_r.wrPtr = r.wrPtr + 2'h1;
      end
      if (doPop) begin
        next_r.rdPtr = r.rdPtr + 2'h1;
      end
      case ({doPush, doPop})
        2'b10: next_r.count = r.count + 3'h1;
        2'b01: next_r.count = r.count - 3'h1;
        default: next_r.count = r.count;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bus.popData = r.mem[r.rdPtr];
  assign bus.full = (r.count == BUF_FULL_COUNT);
  assign bus.empty = (r.count == '0);

endmodule : iecu_capture_buffer

// ===== src/iecu_capture_unit.sv
// input edge capture unit with APB registers and one level interrupt
// assumes capIn and the timer counts are synchronous to mclk
//
// Operation
// - enable clear flushes buffer, clears overflow and counters; no new interrupts
// - idle-stop set halts unit during CPU idle
// - every-edge mode: first edge polarity selectable
// - wide bit selects 32-bit timer capture
// - timer select picks 16-bit source when narrow
// - interrupt after every 1st to 4th event
// - read-only overflow flag set on overflow
// - buffer-not-empty flag shows unread captures
// - mode 111 interrupt only, sleep or idle
// - mode 110 first chosen edge, then all
// - modes 101/100 capture every 16th/4th rise
// - mode 011 rising, 010 falling edges
// - mode 001 captures both edge polarities
// - mode 000 captures nothing
`timescale 1ns/1ps
module iecu_capture_unit
  import iecu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capIn,
  input wire logic [HALF_W-1:0] timerPrimary,
  input wire logic [HALF_W-1:0] timerSecondary,
  input wire logic [DATA_W-1:0] timerWide,
  input wire logic cpuIdle,
  input wire logic cpuSleep,
  output logic irq
);

  typedef struct packed {
    iecu_ctrl_t ctrl;
    logic overflowFlag;
    logic inPrev;
    iecu_phase_t phase;
    logic [3:0] presc;
    logic [1:0] evtCnt;
    logic [IRQ_W-1:0] intStat;
    logic [IRQ_W-1:0] intMask;
    logic [DATA_W-1:0] rdata;
  } iecu_state_t;

  iecu_state_t r;
  iecu_state_t next_r;

  iecu_buf_if bufIf();

  iecu_capture_buffer uBuffer (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(bufIf.buffer)
  );

  logic active;
  logic risingEdge;
  logic fallingEdge;
  logic captureHit;
  logic intOnlyHit;
  logic countEvt;
  logic capIrqEvt;
  logic ovfEvt;
  logic pushReq;
  logic popReq;
  logic flushReq;
  logic setupPhase;
  logic accessPhase;
  logic addrHit;
  logic [DATA_W-1:0] captureValue;
  logic [DATA_W-1:0] ctrlWord;
  logic [DATA_W-1:0] readWord;
  logic [IRQ_W-1:0] setBits;
  logic [IRQ_W-1:0] clrBits;
  logic [2:0] newMode;

  always_comb begin
    next_r = r;
    captureHit = 1'b0;
    intOnlyHit = 1'b0;
    capIrqEvt = 1'b0;
    flushReq = 1'b0;
    clrBits = '0;
    readWord = '0;
    newMode = pwdata[BIT_MODE_HI:BIT_MODE_LO];

    // halted in idle only when asked; otherwise runs through idle
    active = r.ctrl.on && !(r.ctrl.idleStop && cpuIdle);
    risingEdge = capIn && !r.inPrev;
    fallingEdge = !capIn && r.inPrev;
    next_r.inPrev = capIn;

    if (active) begin
      case (r.ctrl.captureMode)
        MODE_OFF: captureHit = 1'b0;
        MODE_EDGE: captureHit = risingEdge || fallingEdge;
        MODE_FALL: captureHit = fallingEdge;
        MODE_RISE: captureHit = risingEdge;
        MODE_DIV4, MODE_DIV16: begin
          if (risingEdge) begin
            // prescaler counts rises only while this mode is selected
            if (r.presc == ((r.ctrl.captureMode == MODE_DIV16) ? PRESC16_LAST
                                                               : PRESC4_LAST)) begin
              captureHit = 1'b1;
              next_r.presc = '0;
            end else begin
              next_r.presc = r.presc + 4'h1;
            end
          end
        end
        MODE_EVERY: begin
          if (r.phase == IECU_WAIT_FIRST) begin
            if (r.ctrl.firstEdgeSelect ? risingEdge : fallingEdge) begin
              captureHit = 1'b1;
              next_r.phase = IECU_RUN;
            end
          end else begin
            captureHit = risingEdge || fallingEdge;
          end
        end
        MODE_INT_ONLY: begin
          // no capture; only meaningful while the CPU sleeps or idles
          intOnlyHit = (cpuSleep || cpuIdle) && (risingEdge || fallingEdge);
        end
        default: captureHit = 1'b0;
      endcase
    end

    if (r.ctrl.wideCapture) begin
      captureValue = timerWide;
    end else if (r.ctrl.timerSelect) begin
      captureValue = {{HALF_W{1'b0}}, timerPrimary};
    end else begin
      captureValue = {{HALF_W{1'b0}}, timerSecondary};
    end

    pushReq = captureHit && !bufIf.full;
    ovfEvt = captureHit && bufIf.full;
    if (ovfEvt) begin
      next_r.overflowFlag = 1'b1;
    end

    countEvt = captureHit || intOnlyHit;
    if (countEvt) begin
      if (r.evtCnt == r.ctrl.interruptRate) begin
        next_r.evtCnt = '0;
        capIrqEvt = 1'b1;
      end else begin
        next_r.evtCnt = r.evtCnt + 2'h1;
      end
    end

    // APB decode; zero wait states
    setupPhase = psel && !penable;
    accessPhase = psel && penable;
    addrHit = (paddr == OFF_CTRL) || (paddr == OFF_BUF) ||
              (paddr == OFF_ISTAT) || (paddr == OFF_IMASK);

    ctrlWord = '0;
    ctrlWord[BIT_ON] = r.ctrl.on;
    ctrlWord[BIT_IDLE_STOP] = r.ctrl.idleStop;
    ctrlWord[BIT_FIRST_EDGE] = r.ctrl.firstEdgeSelect;
    ctrlWord[BIT_WIDE] = r.ctrl.wideCapture;
    ctrlWord[BIT_TIMER_SEL] = r.ctrl.timerSelect;
    ctrlWord[BIT_RATE_HI:BIT_RATE_LO] = r.ctrl.interruptRate;
    ctrlWord[BIT_OVERFLOW] = r.overflowFlag;
    ctrlWord[BIT_NOT_EMPTY] = !bufIf.empty;
    ctrlWord[BIT_MODE_HI:BIT_MODE_LO] = r.ctrl.captureMode;

    case (paddr)
      OFF_CTRL: readWord = ctrlWord;
      OFF_BUF: readWord = bufIf.empty ? '0 : bufIf.popData;
      OFF_ISTAT: readWord = {{(DATA_W-IRQ_W){1'b0}}, r.intStat};
      OFF_IMASK: readWord = {{(DATA_W-IRQ_W){1'b0}}, r.intMask};
      default: readWord = '0;
    endcase
    // read data is latched in the setup cycle so prdata comes from a flop
    if (setupPhase && !pwrite) begin
      next_r.rdata = readWord;
    end

    // buffer word leaves only when the access completes
    popReq = accessPhase && !pwrite && (paddr == OFF_BUF) && !bufIf.empty;

    if (accessPhase && pwrite) begin
      case (paddr)
        OFF_CTRL: begin
          // status bits 4 and 3 are read-only and ignore writes
          next_r.ctrl.on = pwdata[BIT_ON];
          next_r.ctrl.idleStop = pwdata[BIT_IDLE_STOP];
          next_r.ctrl.firstEdgeSelect = pwdata[BIT_FIRST_EDGE];
          next_r.ctrl.wideCapture = pwdata[BIT_WIDE];
          next_r.ctrl.timerSelect = pwdata[BIT_TIMER_SEL];
          next_r.ctrl.interruptRate = pwdata[BIT_RATE_HI:BIT_RATE_LO];
          next_r.ctrl.captureMode = newMode;
          if (newMode != r.ctrl.captureMode) begin
            next_r.phase = IECU_WAIT_FIRST;
            next_r.presc = '0;
          end
        end
        OFF_ISTAT: clrBits = pwdata[IRQ_W-1:0];
        OFF_IMASK: next_r.intMask = pwdata[IRQ_W-1:0];
        default: clrBits = '0;
      endcase
    end

    // a new event beats a write-one-to-clear in the same cycle
    setBits = '0;
    setBits[IST_CAPTURE] = capIrqEvt;
    setBits[IST_OVERFLOW] = ovfEvt;
    next_r.intStat = (r.intStat & ~clrBits) | setBits;

    if (!r.ctrl.on) begin
      flushReq = 1'b1;
      next_r.overflowFlag = 1'b0;
      next_r.evtCnt = '0;
      next_r.presc = '0;
      next_r.phase = IECU_WAIT_FIRST;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bufIf.push = pushReq;
  assign bufIf.pushData = captureValue;
  assign bufIf.pop = popReq;
  assign bufIf.flush = flushReq;

  assign prdata = r.rdata;
  assign pready = 1'b1;
  assign pslverr = accessPhase && !addrHit;
  assign irq = |(r.intStat & r.intMask);

endmodule : iecu_capture_unit

// ===== test/iecu_timer_model.sv
// timer counts seen by the capture unit, free running on mclk
// assumes nothing beyond mclk and rst_n
`timescale 1ns/1ps
module iecu_timer_model
  import iecu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  output logic [HALF_W-1:0] timerPrimary,
  output logic [HALF_W-1:0] timerSecondary,
  output logic [DATA_W-1:0] timerWide
);
  // halves step apart so a wrong source shows
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) timerWide <= 32'h5A5A0001;
    else timerWide <= timerWide + 32'h00030001;
  end
  assign timerPrimary = timerWide[15:0];
  assign timerSecondary = timerWide[31:16];
endmodule : iecu_timer_model

// ===== test/iecu_checker.sv
// assertions on the capture unit's top ports
// assumes cpu state changes only while an APB transfer is under way
`timescale 1ns/1ps
module iecu_checker
  import iecu_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpuIdle,
  input wire logic cpuSleep,
  input wire logic irq
);
  logic acc;
  logic mapped;
  logic [DATA_W-1:0] shCtrl;
  logic [2:0] quiet;
  assign acc = psel && penable;
  assign mapped = paddr inside {OFF_CTRL, OFF_BUF, OFF_ISTAT, OFF_IMASK};
  // idle bus cycles, so that writes have settled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shCtrl <= '0;
      quiet <= '0;
    end else begin
      if (acc && pwrite && paddr == OFF_CTRL) shCtrl <= pwdata & 32'h0000A3E7;
      quiet <= psel ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_bus; acc |-> pready && pslverr == !mapped && (pwrite || mapped || prdata == '0);
  endproperty
  property p_ctrl; acc && !pwrite && paddr == OFF_CTRL |-> (prdata & ~32'h18) == shCtrl;
  endproperty
  property p_flush; acc && !pwrite && paddr == OFF_BUF && !shCtrl[BIT_ON]
    && !$past(shCtrl[BIT_ON], 2) |-> prdata == '0; endproperty
  property p_off; quiet > 3'h2 && !shCtrl[BIT_ON] |-> !$rose(irq); endproperty
  property p_mode0; quiet > 3'h2 && shCtrl[2:0] == MODE_OFF |-> !$rose(irq); endproperty
  property p_halt; quiet > 3'h2 && shCtrl[BIT_IDLE_STOP] && cpuIdle |-> !$rose(irq);
  endproperty
  property p_m7; quiet > 3'h2 && shCtrl[2:0] == MODE_INT_ONLY && !cpuIdle && !cpuSleep
    |-> !$rose(irq); endproperty
  property p_clr; acc && pwrite && paddr == OFF_ISTAT && pwdata[1:0] == 2'h3
    && quiet == 3'h0 |-> ##2 !irq; endproperty
  a_bus: assert property (p_bus) else $error("bus answer wrong");
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  a_flush: assert property (p_flush) else $error("buffer kept");
  a_off: assert property (p_off) else $error("irq while off");
  a_mode0: assert property (p_mode0) else $error("irq in mode 0");
  a_halt: assert property (p_halt) else $error("irq while halted");
  a_m7: assert property (p_m7) else $error("irq-only ran awake");
  a_clr: assert property (p_clr) else $error("irq not cleared");
  c_irq: cover property ($rose(irq));
  c_ovf: cover property (acc && !pwrite && paddr == OFF_CTRL && prdata[BIT_OVERFLOW]);
  c_pop: cover property (acc && !pwrite && paddr == OFF_BUF && prdata != '0);
endmodule : iecu_checker

bind iecu_capture_unit iecu_checker iecu_checker_i(.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irq(irq));

// ===== test/testbench.sv
// bench: APB master, edge driver and a queue model of the capture unit
// assumes free-running timers; cpu state moves only at round starts
`timescale 1ns/1ps
module testbench;
  import iecu_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic capIn = 1'b0;
  logic cpuIdle = 1'b0;
  logic cpuSleep = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] timerWide;
  logic [HALF_W-1:0] timerPrimary;
  logic [HALF_W-1:0] timerSecondary;
  logic pready;
  logic pslverr;
  logic irq;
  int nMismatch = 0;
  int samplesChecked = 0;
  int en, mode, fe, wide, tsel, rate, idleStop, run, pc, cnt, ist, ov;
  logic [DATA_W-1:0] q[$];
  always #12.5 mclk = ~mclk;
  iecu_timer_model iecu_timer_model_i(.mclk(mclk), .rst_n(rst_n), .timerPrimary(timerPrimary),
    .timerSecondary(timerSecondary), .timerWide(timerWide));
  iecu_capture_unit iecu_capture_unit_i(.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capIn(capIn), .timerPrimary(timerPrimary),
    .timerSecondary(timerSecondary), .timerWide(timerWide), .cpuIdle(cpuIdle),
    .cpuSleep(cpuSleep), .irq(irq));
  task automatic finalReport();
    if (nMismatch == 0 && samplesChecked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finalReport
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    samplesChecked++;
    if (g !== e) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one idle cycle after each transfer keeps psel edges apart
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] r;
    apb(1'b0, a, '0, r);
    chk(r, x);
  endtask : rd
  task automatic toggle();
    logic v;
    logic [DATA_W-1:0] t;
    int hit;
    repeat ($urandom_range(2, 0)) @(posedge mclk);
    v = !capIn;
    capIn <= v;
    #1;
    t = wide ? timerWide : {16'h0, tsel ? timerPrimary : timerSecondary};
    @(posedge mclk);
    if (!en || (idleStop && cpuIdle)) return;
    if (v) pc++;
    hit = mode == 1 || (mode == 2 && !v) || (mode == 3 && v)
      || (mode == 6 && (run || v == fe))
      || (v && mode == 4 && pc % 4 == 0) || (v && mode == 5 && pc % 16 == 0);
    if (mode == 6) run = hit;
    if (hit || (mode == 7 && (cpuIdle || cpuSleep))) cnt++;
    if (cnt > rate) begin
      cnt = 0;
      ist |= 1;
    end
    if (hit && q.size() == BUF_DEPTH) begin
      ov = 1;
      ist |= 2;
    end else if (hit) q.push_back(t);
  endtask : toggle
  initial begin
    int r;
    int cfg;
    int mask;
    void'($urandom(36970));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_IMASK, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    for (r = 0; r < 16; r++) begin
      mode = r % 8;
      fe = $urandom_range(1, 0);
      wide = $urandom_range(1, 0);
      tsel = $urandom_range(1, 0);
      rate = $urandom_range(3, 0);
      mask = $urandom_range(3, 0);
      idleStop = r == 9;
      cpuIdle <= r[3] && r != 15;
      cpuSleep <= r == 15;
      cfg = 32'h8000 | idleStop << 13 | fe << 9 | wide << 8 | tsel << 7 | rate << 5 | mode;
      {en, run, pc, cnt, ov} = '0;
      q.delete();
      wr(OFF_CTRL, cfg & 32'h7FFF);
      wr(OFF_IMASK, mask);
      repeat (2) toggle();
      rd(OFF_BUF, 32'h0);
      en = 1;
      wr(OFF_CTRL, cfg | 32'hFFFF0018);
      repeat (mode > 3 ? 34 : 6) toggle();
      repeat (3) @(posedge mclk);
      rd(OFF_CTRL, cfg | (q.size() != 0) << 3 | ov << 4);
      // odd rounds leave one value for the disable to flush
      repeat (q.size() - r % 2) rd(OFF_BUF, q.pop_front());
      if (q.size() == 0) rd(OFF_BUF, 32'h0);
      rd(OFF_ISTAT, ist);
      chk({31'h0, irq}, {31'h0, (ist & mask) != 0});
      wr(OFF_ISTAT, 32'h3);
      ist = 0;
      rd(OFF_ISTAT, 32'h0);
    end
    finalReport();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    nMismatch++;
    finalReport();
  end
endmodule : testbench
